// File: hdl/addr_gen.sv
`timescale 1ns/1ps
module addr_gen (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Request with operand values
	input wire logic req_valid,
	input regfile_pkg::addr_mode_t mode,
	input wire logic [31:0] base_val,
	input wire logic [31:0] index_val,
	input wire logic [2:0] scale_code,
	input wire logic [31:0] disp,
	// Result
	output logic addr_valid_q,
	output logic [31:0] addr_q,
	output logic fault_q
);
	wire logic [31:0] scaled;
	wire logic [31:0] off12;
	wire logic scale_bad;
	logic [31:0] addr_d;

	// Shift gives scale 1..128, codes above 4 fault; wraps in the one 32-bit linear space
	assign scaled = index_val << scale_code;
	assign off12 = {20'h00000, disp[11:0]};
	assign scale_bad = scale_code > regfile_pkg::SCALE_MAX_CODE;

	// Mode selection
	always_comb begin
		addr_d = off12;
		case (mode)
			regfile_pkg::AM_ABS12: addr_d = off12;
			regfile_pkg::AM_ABS32: addr_d = disp;
			regfile_pkg::AM_REG_IND: addr_d = base_val;
			regfile_pkg::AM_REG_OFF12: addr_d = base_val + off12;
			regfile_pkg::AM_REG_OFF32: addr_d = base_val + disp;
			regfile_pkg::AM_REG_INDEX: addr_d = base_val + scaled;
			regfile_pkg::AM_INDEX_DISP: addr_d = scaled + disp;
			regfile_pkg::AM_REG_INDEX_DISP: addr_d = base_val + scaled + disp;
			default: addr_d = off12;
		endcase
	end

	// Registered result, one cycle after the request
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			addr_valid_q <= 1'b0;
			addr_q <= regfile_pkg::RESET_WORD;
			fault_q <= 1'b0;
		end else begin
			addr_valid_q <= req_valid;
			fault_q <= req_valid && scale_bad;
			if (req_valid) begin
				addr_q <= addr_d;
			end
		end
	end

	a_scale_fault: assert property (@(posedge clock) disable iff (rst)
		req_valid && scale_code > 3'h4 |=> fault_q && addr_valid_q)
		else $error("illegal scale not flagged");
	a_abs12_zero: assert property (@(posedge clock) disable iff (rst)
		req_valid && mode == regfile_pkg::AM_ABS12 |=> addr_q[31:12] == 20'h00000)
		else $error("12-bit absolute offset not zero extended");
endmodule

// File: hdl/regfile_pkg.sv
package regfile_pkg;
	localparam int WORD_W = 32;
	localparam int EXT_W = 80;
	localparam int OPND_W = 128;
	localparam int NUM_GLOBALS = 16;
	localparam int NUM_LOCALS = 16;
	localparam int NUM_EXT = 4;
	localparam int NUM_FRAMES = 4;
	localparam int MAX_LOADS = 3;
	localparam int REG_IDX_W = 5;
	localparam int OFFSET_W = 12;
	// Index of stack_frame_pointer_reg among the globals
	localparam logic [3:0] FRAME_PTR_IDX = 4'hf;
	localparam logic [31:0] FRAME_BYTES = 32'h00000040;
	localparam logic [31:0] WORD_BYTES = 32'h00000004;
	localparam logic [2:0] SCALE_MAX_CODE = 3'h4;
	localparam logic [31:0] RESET_WORD = 32'h00000000;
	localparam logic [79:0] RESET_EXT = 80'h0;

	typedef enum logic [2:0] {
		SZ_8 = 3'h0,
		SZ_16 = 3'h1,
		SZ_32 = 3'h2,
		SZ_64 = 3'h3,
		SZ_96 = 3'h4,
		SZ_128 = 3'h5
	} op_size_t;

	typedef enum logic [2:0] {
		AM_ABS12 = 3'h0,
		AM_ABS32 = 3'h1,
		AM_REG_IND = 3'h2,
		AM_REG_OFF12 = 3'h3,
		AM_REG_OFF32 = 3'h4,
		AM_REG_INDEX = 3'h5,
		AM_INDEX_DISP = 3'h6,
		AM_REG_INDEX_DISP = 3'h7
	} addr_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_SPILL = 2'h1,
		ST_FILL_REQ = 2'h2,
		ST_FILL_WAIT = 2'h3
	} frame_state_t;

	typedef struct packed {
		addr_mode_t mode;
		logic [4:0] base_idx;
		logic [4:0] index_idx;
		logic [2:0] scale_code;
		logic [31:0] disp;
	} addr_req_t;

	typedef struct packed {
		logic [4:0] idx;
		op_size_t size;
		logic sign_ext;
		logic [127:0] data;
	} reg_write_t;
endpackage

// File: hdl/register_file_with_frame_cache.sv
// Operation
// - Sixteen 32-bit global registers for all procedures
// - Four 80-bit extended real registers
// - Each call gets sixteen fresh local registers
// - Thirty-two general registers addressable at once
// - Cache holds four local frames on chip
// - Full cache spills oldest frame on call
// - Last global register is the frame pointer
// - Extended registers and globals other than the frame pointer survive calls, returns
// - Any register pair serves real operands
// - Addresses span one 4-gigabyte linear space
// - Base plus offset, absolute and indirect modes
// - Indexed modes add scaled index, displacement
// - Scale limited to 1, 2, 4, 8, 16
// - Ordinals and integers of 8-64 bits
// - Triple and quad words span consecutive registers
// - Load sets pending flag; readers stall until clear
// - At most three loads outstanding
`timescale 1ns/1ps
module register_file_with_frame_cache #(
	parameter int FRAMES = regfile_pkg::NUM_FRAMES,
	parameter int MAX_LOADS = regfile_pkg::MAX_LOADS
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Operand read
	input wire logic rd_valid,
	input wire logic [4:0] rd_idx,
	input regfile_pkg::op_size_t rd_size,
	output logic rd_stall,
	output logic rd_data_valid,
	output logic [127:0] rd_data,
	// Result write
	input wire logic wr_valid,
	input regfile_pkg::reg_write_t wr,
	output logic wr_ready,
	// Extended real registers
	input wire logic ext_wr_valid,
	input wire logic [1:0] ext_wr_idx,
	input wire logic [79:0] ext_wr_data,
	input wire logic [1:0] ext_rd_idx,
	output logic [79:0] ext_rd_data,
	// Load scoreboard
	input wire logic ld_issue,
	input wire logic [4:0] ld_idx,
	output logic ld_ready,
	input wire logic ld_done,
	input wire logic [4:0] ld_done_idx,
	input wire logic [31:0] ld_done_data,
	// Address generation
	input wire logic addr_valid,
	input regfile_pkg::addr_req_t addr_req,
	output logic addr_stall,
	output logic addr_out_valid,
	output logic [31:0] addr_out,
	output logic addr_fault,
	// Procedure call and return
	input wire logic call_req,
	input wire logic ret_req,
	output logic frame_ready,
	// Frame spill memory port
	output logic mem_valid,
	output logic mem_write,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic mem_ready,
	input wire logic mem_rvalid,
	input wire logic [31:0] mem_rdata
);
	localparam int SLOT_W = $clog2(FRAMES);
	localparam logic [SLOT_W:0] FULL = (SLOT_W + 1)'(FRAMES);

	if (FRAMES < 2 || (FRAMES & (FRAMES - 1)) != 0) begin : g_chk_frames
		$error("FRAMES must be a power of two, at least 2");
	end
	if (MAX_LOADS < 1 || MAX_LOADS > 31) begin : g_chk_loads
		$error("MAX_LOADS out of range");
	end

	logic [31:0] globals_q [regfile_pkg::NUM_GLOBALS];
	logic [31:0] frames_q [FRAMES * regfile_pkg::NUM_LOCALS];
	logic [79:0] ext_q [regfile_pkg::NUM_EXT];
	logic [31:0] pending_q;
	logic [SLOT_W-1:0] cur_q;
	logic [SLOT_W:0] used_q;
	logic [15:0] spilled_q;
	logic [3:0] word_q;
	regfile_pkg::frame_state_t state_q;
	logic [127:0] rd_data_q;
	logic rd_data_valid_q;
	logic [79:0] ext_rd_q;

	// Registers covered by a multi-word operand
	function automatic logic [2:0] size_words(input regfile_pkg::op_size_t s);
		case (s)
			regfile_pkg::SZ_64: size_words = 3'h2;
			regfile_pkg::SZ_96: size_words = 3'h3;
			regfile_pkg::SZ_128: size_words = 3'h4;
			default: size_words = 3'h1;
		endcase
	endfunction

	function automatic logic [31:0] reg_mask(input logic [4:0] idx, input regfile_pkg::op_size_t s);
		reg_mask = 32'h00000000;
		for (int k = 0; k < 4; k++) begin
			if (3'(k) < size_words(s)) begin
				reg_mask[idx + 5'(k)] = 1'b1;
			end
		end
	endfunction

	// Upper half of the index space selects the current local frame
	function automatic logic [31:0] reg_word(input logic [4:0] idx);
		reg_word = idx[4] ? frames_q[{cur_q, idx[3:0]}] : globals_q[idx[3:0]];
	endfunction

	// Narrow results widen to a full word
	function automatic logic [31:0] ext_word(input regfile_pkg::reg_write_t w);
		case (w.size)
			regfile_pkg::SZ_8: ext_word = {{24{w.sign_ext & w.data[7]}}, w.data[7:0]};
			regfile_pkg::SZ_16: ext_word = {{16{w.sign_ext & w.data[15]}}, w.data[15:0]};
			default: ext_word = w.data[31:0];
		endcase
	endfunction

	wire logic idle = state_q == regfile_pkg::ST_IDLE;
	wire logic [31:0] frame_pointer = globals_q[regfile_pkg::FRAME_PTR_IDX];
	wire logic [5:0] pend_count = 6'($countones(pending_q));

	// Handshakes; any stall waits for a pending load or a frame move
	assign rd_stall = rd_valid && (!idle || (pending_q & reg_mask(rd_idx, rd_size)) != 0);
	wire logic rd_fire = rd_valid && !rd_stall;
	assign wr_ready = idle;
	wire logic wr_fire = wr_valid && wr_ready;
	assign ld_ready = idle && pend_count < 6'(MAX_LOADS) && !pending_q[ld_idx];
	wire logic ld_fire = ld_issue && ld_ready;

	// Frame moves wait for loads so a local target cannot change frames
	assign frame_ready = idle && pending_q == 32'h00000000;
	wire logic call_fire = call_req && frame_ready;
	wire logic ret_fire = ret_req && frame_ready && !call_req;
	wire logic full = used_q == FULL;

	// Address operands
	wire logic am_base = addr_req.mode != regfile_pkg::AM_ABS12 &&
		addr_req.mode != regfile_pkg::AM_ABS32 && addr_req.mode != regfile_pkg::AM_INDEX_DISP;
	wire logic am_index = addr_req.mode == regfile_pkg::AM_REG_INDEX ||
		addr_req.mode == regfile_pkg::AM_INDEX_DISP || addr_req.mode == regfile_pkg::AM_REG_INDEX_DISP;
	assign addr_stall = addr_valid && (!idle || (am_base && pending_q[addr_req.base_idx]) ||
		(am_index && pending_q[addr_req.index_idx]));

	// Spill memory port; oldest slot is the one after the current
	wire logic [SLOT_W-1:0] old_slot = cur_q + SLOT_W'(1);
	wire logic [SLOT_W-1:0] fill_slot = cur_q - SLOT_W'(1);
	wire logic [31:0] word_off = {26'h0, word_q, 2'h0};
	assign mem_valid = state_q == regfile_pkg::ST_SPILL || state_q == regfile_pkg::ST_FILL_REQ;
	assign mem_write = state_q == regfile_pkg::ST_SPILL;
	assign mem_addr = mem_write ? frame_pointer + word_off :
		frame_pointer - regfile_pkg::FRAME_BYTES + word_off;
	assign mem_wdata = frames_q[{old_slot, word_q}];
	wire logic spill_step = mem_write && mem_ready;
	wire logic fill_step = state_q == regfile_pkg::ST_FILL_WAIT && mem_rvalid;
	wire logic last_word = word_q == 4'hf;

	assign rd_data = rd_data_q;
	assign rd_data_valid = rd_data_valid_q;
	assign ext_rd_data = ext_rd_q;

	// Address unit
	addr_gen u_addr_gen (
		.clock(clock),
		.rst(rst),
		.req_valid(addr_valid && !addr_stall),
		.mode(addr_req.mode),
		.base_val(reg_word(addr_req.base_idx)),
		.index_val(reg_word(addr_req.index_idx)),
		.scale_code(addr_req.scale_code),
		.disp(addr_req.disp),
		.addr_valid_q(addr_out_valid),
		.addr_q(addr_out),
		.fault_q(addr_fault)
	);

	// Frame cache sequencer
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= regfile_pkg::ST_IDLE;
			cur_q <= '0;
			used_q <= (SLOT_W + 1)'(1);
			spilled_q <= 16'h0000;
			word_q <= 4'h0;
		end else begin
			case (state_q)
				regfile_pkg::ST_IDLE: begin
					word_q <= 4'h0;
					if (call_fire && full) begin
						state_q <= regfile_pkg::ST_SPILL;
					end else if (call_fire) begin
						cur_q <= cur_q + SLOT_W'(1);
						used_q <= used_q + (SLOT_W + 1)'(1);
					end else if (ret_fire && used_q > (SLOT_W + 1)'(1)) begin
						cur_q <= fill_slot;
						used_q <= used_q - (SLOT_W + 1)'(1);
					end else if (ret_fire && spilled_q != 16'h0000) begin
						state_q <= regfile_pkg::ST_FILL_REQ;
					end
				end
				regfile_pkg::ST_SPILL: begin
					if (spill_step) begin
						word_q <= word_q + 4'h1;
						if (last_word) begin
							cur_q <= old_slot;
							spilled_q <= spilled_q + 16'h0001;
							state_q <= regfile_pkg::ST_IDLE;
						end
					end
				end
				regfile_pkg::ST_FILL_REQ: begin
					if (mem_ready) begin
						state_q <= regfile_pkg::ST_FILL_WAIT;
					end
				end
				regfile_pkg::ST_FILL_WAIT: begin
					if (fill_step) begin
						word_q <= word_q + 4'h1;
						state_q <= regfile_pkg::ST_FILL_REQ;
						if (last_word) begin
							cur_q <= fill_slot;
							spilled_q <= spilled_q - 16'h0001;
							state_q <= regfile_pkg::ST_IDLE;
						end
					end
				end
				default: state_q <= regfile_pkg::ST_IDLE;
			endcase
		end
	end

	// Storage; a load return to the same register lands after the write
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < regfile_pkg::NUM_GLOBALS; i++) globals_q[i] <= regfile_pkg::RESET_WORD;
			for (int i = 0; i < FRAMES * regfile_pkg::NUM_LOCALS; i++) frames_q[i] <= regfile_pkg::RESET_WORD;
			for (int i = 0; i < regfile_pkg::NUM_EXT; i++) ext_q[i] <= regfile_pkg::RESET_EXT;
		end else begin
			if (wr_fire) begin
				for (int k = 0; k < 4; k++) begin
					if (3'(k) < size_words(wr.size)) begin
						if (wr.idx[4] ^ ((wr.idx[3:0] + 5'(k)) > 5'hf)) begin
							frames_q[{cur_q, 4'(wr.idx[3:0] + 4'(k))}] <= (k == 0) ? ext_word(wr) : wr.data[k*32 +: 32];
						end else begin
							globals_q[4'(wr.idx[3:0] + 4'(k))] <= (k == 0) ? ext_word(wr) : wr.data[k*32 +: 32];
						end
					end
				end
			end
			if (ld_done && ld_done_idx[4]) frames_q[{cur_q, ld_done_idx[3:0]}] <= ld_done_data;
			if (ld_done && !ld_done_idx[4]) globals_q[ld_done_idx[3:0]] <= ld_done_data;
			if (fill_step) frames_q[{fill_slot, word_q}] <= mem_rdata;
			// Frame pointer walks the memory stack one frame per move
			if (spill_step && last_word) begin
				globals_q[regfile_pkg::FRAME_PTR_IDX] <= frame_pointer + regfile_pkg::FRAME_BYTES;
			end
			if (fill_step && last_word) begin
				globals_q[regfile_pkg::FRAME_PTR_IDX] <= frame_pointer - regfile_pkg::FRAME_BYTES;
			end
			if (ext_wr_valid) ext_q[ext_wr_idx] <= ext_wr_data;
		end
	end

	// Read data, scoreboard and extended read
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_data_q <= 128'h0;
			rd_data_valid_q <= 1'b0;
			pending_q <= 32'h00000000;
			ext_rd_q <= regfile_pkg::RESET_EXT;
		end else begin
			rd_data_valid_q <= rd_fire;
			if (rd_fire) begin
				for (int k = 0; k < 4; k++) begin
					rd_data_q[k*32 +: 32] <= (3'(k) < size_words(rd_size)) ? reg_word(rd_idx + 5'(k)) : 32'h0;
				end
			end
			// Set wins over a clear of the same flag
			pending_q <= (pending_q & ~(ld_done ? (32'h1 << ld_done_idx) : 32'h0)) |
				(ld_fire ? (32'h1 << ld_idx) : 32'h0);
			ext_rd_q <= ext_q[ext_rd_idx];
		end
	end

	a_load_limit: assert property (@(posedge clock) disable iff (rst)
		pend_count <= 6'(MAX_LOADS))
		else $error("too many loads pending");
	a_load_sets: assert property (@(posedge clock) disable iff (rst)
		ld_fire |=> pending_q[$past(ld_idx)])
		else $error("load did not set pending flag");
	a_read_waits: assert property (@(posedge clock) disable iff (rst)
		rd_valid && pending_q[rd_idx] |-> rd_stall ##1 !rd_data_valid)
		else $error("read of pending register not stalled");
	a_spill_on_full: assert property (@(posedge clock) disable iff (rst)
		call_fire && full |=> state_q == regfile_pkg::ST_SPILL [*8])
		else $error("full call did not start a spill");
	a_spill_moves_ptr: assert property (@(posedge clock) disable iff (rst)
		spill_step && last_word |=> frame_pointer == $past(frame_pointer) + 32'h40 && idle)
		else $error("frame pointer not advanced after spill");
	a_fill_on_ret: assert property (@(posedge clock) disable iff (rst)
		ret_fire && used_q == 1 && spilled_q != 0 |=> !idle ##1 rd_valid |-> rd_stall)
		else $error("return to spilled frame not refilled");
	a_globals_kept: assert property (@(posedge clock) disable iff (rst)
		call_fire && !wr_fire && !ld_done |=> globals_q[0] == $past(globals_q[0]))
		else $error("global changed by call");
	a_frames_bound: assert property (@(posedge clock) disable iff (rst)
		used_q >= 1 && used_q <= FULL)
		else $error("frame occupancy out of range");
endmodule

// File: test/spill_mem_model.sv
`timescale 1ns/1ps
// Memory stack behind the frame spill port
module spill_mem_model (
	// Clock and answer latency
	input wire logic clock,
	input wire logic [1:0] lat,
	// Spill port
	input wire logic mem_valid,
	input wire logic mem_write,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic mem_ready,
	output logic mem_rvalid,
	output logic [31:0] mem_rdata,
	// Count of words written
	output logic [7:0] n_wr
);
	logic [31:0] mem [0:63];
	logic [1:0] wait_q;
	logic [5:0] rd_word;
	logic rd_pend;

	// Quiet start, no reset pin on this side
	initial begin
		mem_ready = 1'b0;
		mem_rvalid = 1'b0;
		mem_rdata = 32'h0;
		n_wr = 8'h0;
		wait_q = 2'h0;
		rd_pend = 1'b0;
		rd_word = 6'h0;
	end

	// Ready after lat idle cycles, read data one cycle after ready
	always @(posedge clock) begin
		mem_ready <= 1'b0;
		mem_rvalid <= rd_pend;
		rd_pend <= 1'b0;
		// Idle data line flips so stale data never looks valid
		mem_rdata <= rd_pend ? mem[rd_word] : ~mem_rdata;
		if (mem_valid && !mem_ready) begin
			wait_q <= wait_q + 2'h1;
			if (wait_q == lat) begin
				wait_q <= 2'h0;
				mem_ready <= 1'b1;
				rd_word <= mem_addr[7:2];
				rd_pend <= !mem_write;
				if (mem_write) begin
					mem[mem_addr[7:2]] <= mem_wdata;
					n_wr <= n_wr + 8'h1;
				end
			end
		end
	end
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic clock, rst, rd_valid, wr_valid, ext_wr_valid, ld_issue, ld_done, addr_valid;
	logic call_req, ret_req, rd_stall, rd_data_valid, wr_ready, ld_ready, addr_stall;
	logic addr_out_valid, addr_fault, frame_ready, mem_valid, mem_write, mem_ready, mem_rvalid;
	logic [4:0] rd_idx, ld_idx, ld_done_idx;
	logic [1:0] ext_wr_idx, ext_rd_idx, lat;
	logic [79:0] ext_wr_data, ext_rd_data;
	logic [31:0] ld_done_data, addr_out, mem_addr, mem_wdata, mem_rdata;
	logic [127:0] rd_data;
	logic [7:0] n_wr;
	regfile_pkg::op_size_t rd_size;
	regfile_pkg::reg_write_t wr;
	regfile_pkg::addr_req_t addr_req;
	int n_errors, n_tests;

	register_file_with_frame_cache register_file_with_frame_cache_i (.*);
	spill_mem_model spill_mem_model_i (.*);

	// 25 MHz clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Bounded wait, sampled mid-cycle so edge updates have landed
	task automatic wait_go(ref logic s, input logic lvl);
		int k;
		k = 0;
		@(negedge clock);
		while (s !== lvl && k < 300) begin
			@(negedge clock);
			k++;
		end
		if (s !== lvl) chk("handshake", 128'h1, 128'h0);
	endtask

	task automatic wr_reg(input logic [4:0] i, input regfile_pkg::op_size_t sz, input logic se,
		input logic [127:0] d);
		@(posedge clock);
		wr_valid <= 1'b1;
		wr <= '{idx: i, size: sz, sign_ext: se, data: d};
		wait_go(wr_ready, 1'b1);
		@(posedge clock);
		wr_valid <= 1'b0;
	endtask

	task automatic rd_chk(input string nm, input logic [4:0] i, input regfile_pkg::op_size_t sz,
		input logic [127:0] e);
		@(posedge clock);
		rd_valid <= 1'b1;
		rd_idx <= i;
		rd_size <= sz;
		wait_go(rd_stall, 1'b0);
		@(posedge clock);
		rd_valid <= 1'b0;
		@(negedge clock);
		chk({nm, " valid"}, 128'h1, {127'h0, rd_data_valid});
		chk(nm, e, rd_data);
	endtask

	task automatic addr_chk(input string nm, input regfile_pkg::addr_mode_t m,
		input logic [2:0] s, input logic [31:0] d, input logic [31:0] e, input logic f);
		@(posedge clock);
		addr_valid <= 1'b1;
		addr_req <= '{mode: m, base_idx: 5'h01, index_idx: 5'h02, scale_code: s, disp: d};
		wait_go(addr_stall, 1'b0);
		@(posedge clock);
		addr_valid <= 1'b0;
		@(negedge clock);
		chk({nm, " fault"}, {127'h0, f}, {127'h0, addr_fault});
		if (!f) begin
			chk({nm, " valid"}, 128'h1, {127'h0, addr_out_valid});
			chk(nm, {96'h0, e}, {96'h0, addr_out});
		end
	endtask

	// Call when c is high, return otherwise; waits out any spill or fill
	task automatic frame(input logic c);
		@(posedge clock);
		call_req <= c;
		ret_req <= !c;
		wait_go(frame_ready, 1'b1);
		@(posedge clock);
		call_req <= 1'b0;
		ret_req <= 1'b0;
		wait_go(frame_ready, 1'b1);
	endtask

	task automatic t_regs;
		wr_reg(5'h03, regfile_pkg::SZ_128, 1'b0, 128'h44444444333333332222222211111111);
		rd_chk("quad", 5'h03, regfile_pkg::SZ_128, 128'h44444444333333332222222211111111);
		rd_chk("triple", 5'h03, regfile_pkg::SZ_96, 128'h333333332222222211111111);
		rd_chk("g4", 5'h04, regfile_pkg::SZ_32, 128'h22222222);
		wr_reg(5'h14, regfile_pkg::SZ_8, 1'b1, 128'h80);
		rd_chk("sext", 5'h14, regfile_pkg::SZ_32, 128'hffffff80);
		wr_reg(5'h15, regfile_pkg::SZ_16, 1'b0, 128'h1f234);
		rd_chk("zext16", 5'h15, regfile_pkg::SZ_32, 128'hf234);
		wr_reg(5'h1e, regfile_pkg::SZ_64, 1'b0, 128'h89abcdef01234567);
		rd_chk("pair", 5'h1e, regfile_pkg::SZ_64, 128'h89abcdef01234567);
	endtask

	task automatic t_ext;
		@(posedge clock);
		ext_wr_valid <= 1'b1;
		ext_wr_idx <= 2'h2;
		ext_wr_data <= 80'h4000c90fdaa22168c235;
		@(posedge clock);
		ext_wr_idx <= 2'h1;
		ext_wr_data <= 80'hbfff8000000000000001;
		@(posedge clock);
		ext_wr_valid <= 1'b0;
		ext_rd_idx <= 2'h2;
		@(posedge clock);
		ext_rd_idx <= 2'h1;
		@(negedge clock);
		chk("ext2", 128'h4000c90fdaa22168c235, {48'h0, ext_rd_data});
		@(negedge clock);
		chk("ext1", 128'hbfff8000000000000001, {48'h0, ext_rd_data});
	endtask

	task automatic t_loads;
		for (int i = 5; i < 8; i++) begin
			@(posedge clock);
			ld_issue <= 1'b1;
			ld_idx <= 5'(i);
			wait_go(ld_ready, 1'b1);
			@(posedge clock);
			ld_issue <= 1'b0;
		end
		// Free target, so only the count of pending loads can refuse it
		ld_idx <= 5'h08;
		@(negedge clock);
		chk("ld_ready full", 128'h0, {127'h0, ld_ready});
		@(posedge clock);
		rd_valid <= 1'b1;
		rd_idx <= 5'h05;
		rd_size <= regfile_pkg::SZ_32;
		addr_valid <= 1'b1;
		addr_req <= '{mode: regfile_pkg::AM_REG_IND, base_idx: 5'h06, index_idx: 5'h00,
			scale_code: 3'h0, disp: 32'h0};
		repeat (3) begin
			@(negedge clock);
			chk("stall", 128'h1, {127'h0, rd_stall});
			chk("addr stall", 128'h1, {127'h0, addr_stall});
		end
		@(posedge clock);
		addr_valid <= 1'b0;
		ld_done <= 1'b1;
		ld_done_idx <= 5'h05;
		ld_done_data <= 32'h5a5a0005;
		@(posedge clock);
		ld_done_idx <= 5'h06;
		@(posedge clock);
		ld_done_idx <= 5'h07;
		wait_go(rd_stall, 1'b0);
		@(posedge clock);
		ld_done <= 1'b0;
		rd_valid <= 1'b0;
		@(negedge clock);
		chk("load data", 128'h5a5a0005, rd_data);
	endtask

	task automatic t_addr;
		wr_reg(5'h01, regfile_pkg::SZ_32, 1'b0, 128'h100);
		wr_reg(5'h02, regfile_pkg::SZ_32, 1'b0, 128'h3);
		addr_chk("abs12", regfile_pkg::AM_ABS12, 3'h0, 32'hfffff123, 32'h123, 1'b0);
		addr_chk("abs32", regfile_pkg::AM_ABS32, 3'h0, 32'h80000004, 32'h80000004, 1'b0);
		addr_chk("ind", regfile_pkg::AM_REG_IND, 3'h0, 32'h0, 32'h100, 1'b0);
		addr_chk("off12", regfile_pkg::AM_REG_OFF12, 3'h0, 32'hfffff123, 32'h223, 1'b0);
		addr_chk("wrap", regfile_pkg::AM_REG_OFF32, 3'h0, 32'hffffff00, 32'h0, 1'b0);
		addr_chk("idx16", regfile_pkg::AM_REG_INDEX, 3'h4, 32'h0, 32'h130, 1'b0);
		addr_chk("idxd", regfile_pkg::AM_INDEX_DISP, 3'h3, 32'h1000, 32'h1018, 1'b0);
		addr_chk("full", regfile_pkg::AM_REG_INDEX_DISP, 3'h0, 32'h10, 32'h113, 1'b0);
		addr_chk("bad", regfile_pkg::AM_REG_INDEX, 3'h5, 32'h0, 32'h0, 1'b1);
	endtask

	task automatic t_frames;
		wr_reg(5'h10, regfile_pkg::SZ_32, 1'b0, 128'ha5a5);
		wr_reg(5'h00, regfile_pkg::SZ_32, 1'b0, 128'h11);
		frame(1'b1);
		wr_reg(5'h10, regfile_pkg::SZ_32, 1'b0, 128'hbbbb);
		frame(1'b1);
		frame(1'b1);
		chk("no spill", 128'h0, {120'h0, n_wr});
		frame(1'b1);
		chk("spill", 128'h10, {120'h0, n_wr});
		chk("spilled local", 128'ha5a5, {96'h0, spill_mem_model_i.mem[0]});
		rd_chk("frame pointer", 5'h0f, regfile_pkg::SZ_32, 128'h40);
		rd_chk("first global", 5'h00, regfile_pkg::SZ_32, 128'h11);
		chk("ext kept", 128'hbfff8000000000000001, {48'h0, ext_rd_data});
		// Slow memory on the way back
		@(posedge clock);
		lat <= 2'h2;
		repeat (4) frame(1'b0);
		rd_chk("refill", 5'h10, regfile_pkg::SZ_32, 128'ha5a5);
		rd_chk("frame pointer back", 5'h0f, regfile_pkg::SZ_32, 128'h0);
	endtask

	task final_report;
		if (n_errors == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Main sequence, reset held two cycles
	initial begin
		{rst, rd_valid, wr_valid, ext_wr_valid, ld_issue, ld_done, addr_valid} = 7'h40;
		{call_req, ret_req, rd_idx, ld_idx, ld_done_idx, ext_wr_idx, ext_rd_idx, lat} = '0;
		{ext_wr_data, ld_done_data} = '0;
		rd_size = regfile_pkg::SZ_32;
		wr = '0;
		addr_req = '0;
		n_errors = 0;
		n_tests = 0;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		t_regs;
		t_ext;
		t_loads;
		t_addr;
		t_frames;
		final_report;
	end

	// Watchdog well past the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		final_report;
	end
endmodule
